// File: prc_pkg.sv
package prc_pkg;

  // Register byte offsets inside the block's AHB window.
  localparam logic [11:0] PRC_ADDR_CTRL   = 12'h000;
  localparam logic [11:0] PRC_ADDR_STATUS = 12'h004;

  // Field positions of the performance report control register.
  localparam int PRC_LBO_EN_BIT = 7;
  localparam int PRC_LOS_EN_BIT = 6;
  localparam int PRC_CR_BIT     = 2;
  localparam int PRC_MODE_LSB   = 0;

  // Reset value and writable-bit mask; bits 5:3 are reserved and read zero.
  localparam logic [7:0] PRC_CTRL_RESET = 8'h40;
  localparam logic [7:0] PRC_CTRL_MASK  = 8'hC7;

  // Status register fields.
  localparam int PRC_STAT_CNT_LSB = 8;
  localparam int PRC_STAT_LBO_BIT = 1;
  localparam int PRC_STAT_PER_BIT = 0;

  // Report mode encodings.
  localparam logic [1:0] PRC_MODE_OFF      = 2'h0;
  localparam logic [1:0] PRC_MODE_SINGLE   = 2'h1;
  localparam logic [1:0] PRC_MODE_PERIODIC = 2'h2;
  localparam logic [1:0] PRC_MODE_OFF_ALT  = 2'h3;

  // Timing: nominal T1 frame period and frames per second.
  localparam int PRC_CLK_PERIOD_NS  = 10;
  localparam int PRC_FRAME_TIME_NS  = 125000;
  localparam int PRC_FRAME_CYCLES   = PRC_FRAME_TIME_NS / PRC_CLK_PERIOD_NS;
  localparam int PRC_FRAMES_PER_SEC = 8000;

  // Widths.
  localparam int PRC_SUMMARY_W = 16;
  localparam int PRC_EQ_W      = 5;

  // One outgoing performance report as handed to the LAPD transmitter.
  typedef struct packed {
    logic                     cr;
    logic [PRC_SUMMARY_W-1:0] summary;
  } prc_report_t;

endpackage : prc_pkg

// File: prc_buildout.sv
module prc_buildout import prc_pkg::*; (
  input  wire logic                hclk,        // System clock.
  input  wire logic                hresetn,     // Asynchronous reset, active low.
  input  wire logic                enable,      // Auto lowering enabled by software.
  input  wire logic                ais_sending, // Transmitter is sending AIS.
  input  wire logic                short_haul,  // Channel is in T1 short haul mode.
  input  wire logic [PRC_EQ_W-1:0] setting_in,  // Configured build-out setting.
  output logic      [PRC_EQ_W-1:0] setting_out, // Build-out setting applied.
  output logic                     lowered      // Reduction currently applied.
);

  logic [PRC_EQ_W-1:0] setting_q, setting_d;
  logic                lowered_q, lowered_d;
  logic                active;

  // Lowering needs all three conditions; setting zero has no lower step.
  always_comb begin
    active    = enable && ais_sending && short_haul;
    setting_d = setting_in;
    lowered_d = 1'b0;
    if (active && (setting_in != '0)) begin
      setting_d = PRC_EQ_W'(setting_in - 5'h01);
      lowered_d = 1'b1;
    end
  end

  // Registered so the line driver never sees a combinational glitch.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      setting_q <= '0;
      lowered_q <= 1'b0;
    end else begin
      setting_q <= setting_d;
      lowered_q <= lowered_d;
    end
  end

  assign setting_out = setting_q;
  assign lowered     = lowered_q;

  chk_lbo_lowers_one: assert property (@(posedge hclk) disable iff (!hresetn)
    (enable && ais_sending && short_haul && setting_in != '0)
      |=> (setting_out == PRC_EQ_W'($past(setting_in) - 5'h01)) && lowered)
    else $error("build-out not lowered by one setting");

  chk_lbo_no_adjust: assert property (@(posedge hclk) disable iff (!hresetn)
    !(enable && ais_sending && short_haul) |=> (setting_out == $past(setting_in)) && !lowered)
    else $error("build-out adjusted without all conditions");

  cov_lbo_lowered: cover property (@(posedge hclk) disable iff (!hresetn) $rose(lowered));

endmodule : prc_buildout

// File: prc_report_gen.sv
module prc_report_gen import prc_pkg::*; #(
  parameter int FRAME_CYCLES   = PRC_FRAME_CYCLES,   // Clock cycles per frame.
  parameter int FRAMES_PER_SEC = PRC_FRAMES_PER_SEC  // Frames per report period.
)(
  input  wire logic                 hclk,         // System clock.
  input  wire logic                 hresetn,      // Asynchronous reset, active low.
  input  wire logic [1:0]           mode,         // Automatic report mode.
  input  wire logic                 cr_bit,       // Command/response control bit.
  input  wire logic [PRC_SUMMARY_W-1:0] counter_summary, // Counter summary.
  output logic                      report_valid, // One-cycle report strobe.
  output prc_report_t               report        // Report contents.
);

  localparam int DW = $clog2(FRAME_CYCLES);
  localparam int FW = $clog2(FRAMES_PER_SEC);

  logic [1:0]    mode_prev_q;
  logic [DW-1:0] div_q, div_d;
  logic [FW-1:0] frame_q, frame_d;
  logic          valid_q, valid_d;
  prc_report_t   report_q, report_d;
  logic          frame_en, periodic, fire;

  // Frame divider and frame counter run only in periodic mode, from zero.
  always_comb begin
    periodic = (mode == PRC_MODE_PERIODIC);
    frame_en = (div_q == DW'(FRAME_CYCLES - 1));
    div_d    = '0;
    frame_d  = '0;
    if (periodic) begin
      div_d   = frame_en ? '0 : DW'(div_q + 1'b1);
      frame_d = frame_q;
      if (frame_en) begin
        frame_d = (frame_q == FW'(FRAMES_PER_SEC - 1)) ? '0 : FW'(frame_q + 1'b1);
      end
    end
  end

  // Single reports fire only on the 00 to 01 edge; modes 00 and 11 never fire.
  always_comb begin
    fire = ((mode == PRC_MODE_SINGLE) && (mode_prev_q == PRC_MODE_OFF))
        || (periodic && frame_en && (frame_q == FW'(FRAMES_PER_SEC - 1)));
    valid_d  = fire;
    report_d = report_q;
    if (fire) begin
      report_d.cr      = cr_bit;
      report_d.summary = counter_summary;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_prev_q <= PRC_MODE_OFF;
      div_q       <= '0;
      frame_q     <= '0;
      valid_q     <= 1'b0;
      report_q    <= '0;
    end else begin
      mode_prev_q <= mode;
      div_q       <= div_d;
      frame_q     <= frame_d;
      valid_q     <= valid_d;
      report_q    <= report_d;
    end
  end

  assign report_valid = valid_q;
  assign report       = report_q;

  chk_single_on_edge: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == PRC_MODE_SINGLE && mode_prev_q == PRC_MODE_OFF) |=> report_valid)
    else $error("no report on 00 to 01 edge");

  chk_single_once: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == PRC_MODE_SINGLE && mode_prev_q == PRC_MODE_SINGLE) |=> !report_valid)
    else $error("repeated single report");

  chk_off_silent: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == PRC_MODE_OFF || mode == PRC_MODE_OFF_ALT) |=> !report_valid)
    else $error("report issued while disabled");

  chk_period_fire: assert property (@(posedge hclk) disable iff (!hresetn)
    (periodic && frame_en && frame_q == FW'(FRAMES_PER_SEC - 1)) |=> report_valid)
    else $error("periodic report missing");

  chk_period_restart: assert property (@(posedge hclk) disable iff (!hresetn)
    !periodic |=> (frame_q == '0) && (div_q == '0))
    else $error("interval count not restarted");

  chk_report_fields: assert property (@(posedge hclk) disable iff (!hresetn)
    report_valid |-> (report.cr == $past(cr_bit)) && (report.summary == $past(counter_summary)))
    else $error("report fields not copied");

  cov_single: cover property (@(posedge hclk) disable iff (!hresetn)
    mode == PRC_MODE_SINGLE ##1 report_valid);
  cov_periodic: cover property (@(posedge hclk) disable iff (!hresetn)
    periodic && report_valid);

endmodule : prc_report_gen

// File: prc_top.sv
// How it works
// - With auto lowering enabled and AIS being sent, the build-out setting drops one step.
// - The lowering only happens when the channel runs in T1 short haul mode.
// - The loss-of-signal enable bit gates the loss pin, and it resets to 1.
// - Each report carries the command/response control bit as its C/R bit.
// - Each report summarises the current counter status for the LAPD transmitter.
// - Report mode 00 or 11 issues no report.
// - Exactly one report is issued each time the mode goes from 00 to 01.
// - Report mode 10 issues one report every second with no software action.
module prc_top import prc_pkg::*; #(
  parameter int FRAME_CYCLES   = PRC_FRAME_CYCLES,   // Clock cycles per T1 frame.
  parameter int FRAMES_PER_SEC = PRC_FRAMES_PER_SEC  // Frames per report period.
)(
  input  wire logic                 hclk,                      // Clock, 100 MHz.
  input  wire logic                 hresetn,                   // Async reset, active low.
  input  wire logic                 hsel,                      // AHB slave select.
  input  wire logic [31:0]          haddr,                     // AHB address.
  input  wire logic [1:0]           htrans,                    // AHB transfer type.
  input  wire logic                 hwrite,                    // AHB write flag.
  input  wire logic [2:0]           hsize,                     // AHB transfer size.
  input  wire logic [31:0]          hwdata,                    // AHB write data.
  input  wire logic                 hready,                    // AHB bus ready.
  output logic                      hreadyout,                 // Slave ready.
  output logic                      hresp,                     // Slave response.
  output logic [31:0]               hrdata,                    // Read data.
  input  wire logic                 ais_sending,               // Transmitter sends AIS.
  input  wire logic                 short_haul,                // T1 short haul config.
  input  wire logic [PRC_EQ_W-1:0]  equalizer_setting,         // Configured build-out.
  output logic      [PRC_EQ_W-1:0]  equalizer_setting_out,     // Applied build-out.
  input  wire logic                 signal_loss_detect,        // Receive LOS detected.
  output logic                      signal_loss_output_pin_n,  // LOS pin, active low.
  input  wire logic [PRC_SUMMARY_W-1:0] performance_monitor_counters, // Counter summary.
  output logic                      report_valid,              // Report strobe.
  output prc_report_t               report                     // Report for LAPD.
);

  logic [7:0]  performance_report_control_q;
  logic [7:0]  performance_report_control_d;
  logic        wr_pend_q, wr_pend_d;
  logic [11:0] wr_addr_q, wr_addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic        hreadyout_q;
  logic        hresp_q;
  logic [7:0]  rpt_cnt_q, rpt_cnt_d;
  logic        los_pin_n_q, los_pin_n_d;
  logic        addr_phase;
  logic        lbo_lowered;
  logic        rpt_valid;
  logic [1:0]  auto_report_mode;
  logic        buildout_auto_lower_enable;
  logic        signal_loss_pin_enable;
  logic        cr_control;

  // Named views of the control fields.
  assign auto_report_mode           = performance_report_control_q[PRC_MODE_LSB +: 2];
  assign buildout_auto_lower_enable = performance_report_control_q[PRC_LBO_EN_BIT];
  assign signal_loss_pin_enable     = performance_report_control_q[PRC_LOS_EN_BIT];
  assign cr_control                 = performance_report_control_q[PRC_CR_BIT];

  // A transfer is taken when selected, ready and NONSEQ or SEQ.
  assign addr_phase = hsel && hready && htrans[1];

  // Writes land in the data phase, the cycle after the address phase.
  always_comb begin
    wr_pend_d = addr_phase && hwrite;
    wr_addr_d = addr_phase ? haddr[11:0] : wr_addr_q;
    performance_report_control_d = performance_report_control_q;
    if (wr_pend_q && (wr_addr_q == PRC_ADDR_CTRL)) begin
      performance_report_control_d = hwdata[7:0] & PRC_CTRL_MASK;
    end
  end

  // Read data is registered at the address-phase edge. The control value is
  // taken from its next-state so a read right behind a write sees the new data.
  always_comb begin
    hrdata_d = hrdata_q;
    if (addr_phase && !hwrite) begin
      unique case (haddr[11:0])
        PRC_ADDR_CTRL: begin
          hrdata_d = {24'h000000, performance_report_control_d};
        end
        PRC_ADDR_STATUS: begin
          hrdata_d = 32'h00000000;
          hrdata_d[PRC_STAT_CNT_LSB +: 8] = rpt_cnt_q;
          hrdata_d[PRC_STAT_LBO_BIT]      = lbo_lowered;
          hrdata_d[PRC_STAT_PER_BIT]      = (auto_report_mode == PRC_MODE_PERIODIC);
        end
        default: begin
          hrdata_d = 32'h00000000;
        end
      endcase
    end
  end

  // Bus state registers; the slave never stalls and always answers OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 12'h000;
      hrdata_q    <= 32'h00000000;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      wr_pend_q   <= wr_pend_d;
      wr_addr_q   <= wr_addr_d;
      hrdata_q    <= hrdata_d;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
  end

  // Control register; the loss pin enable comes out of reset set.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      performance_report_control_q <= PRC_CTRL_RESET;
    end else begin
      performance_report_control_q <= performance_report_control_d;
    end
  end

  // The pin drives LOS only while enabled, otherwise it rests inactive high.
  // Reports issued are counted for software, wrapping at 255.
  always_comb begin
    los_pin_n_d = !(signal_loss_detect && signal_loss_pin_enable);
    rpt_cnt_d   = rpt_valid ? 8'(rpt_cnt_q + 8'h01) : rpt_cnt_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      los_pin_n_q <= 1'b1;
      rpt_cnt_q   <= 8'h00;
    end else begin
      los_pin_n_q <= los_pin_n_d;
      rpt_cnt_q   <= rpt_cnt_d;
    end
  end

  // Report generation for single and periodic modes.
  prc_report_gen #(
    .FRAME_CYCLES   (FRAME_CYCLES),
    .FRAMES_PER_SEC (FRAMES_PER_SEC)
  ) u_report_gen (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .mode         (auto_report_mode),
    .cr_bit       (cr_control),
    .counter_summary (performance_monitor_counters),
    .report_valid (rpt_valid),
    .report       (report)
  );

  // Build-out reduction while AIS is sent.
  prc_buildout u_buildout (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .enable      (buildout_auto_lower_enable),
    .ais_sending (ais_sending),
    .short_haul  (short_haul),
    .setting_in  (equalizer_setting),
    .setting_out (equalizer_setting_out),
    .lowered     (lbo_lowered)
  );

  assign hreadyout                = hreadyout_q;
  assign hresp                    = hresp_q;
  assign hrdata                   = hrdata_q;
  assign signal_loss_output_pin_n = los_pin_n_q;
  assign report_valid             = rpt_valid;

  chk_los_gated_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !signal_loss_pin_enable |=> signal_loss_output_pin_n)
    else $error("loss pin driven while disabled");

  chk_los_driven: assert property (@(posedge hclk) disable iff (!hresetn)
    (signal_loss_detect && signal_loss_pin_enable) |=> !signal_loss_output_pin_n)
    else $error("loss pin not driven while enabled");

  chk_ctrl_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_phase && hwrite && haddr[11:0] == PRC_ADDR_CTRL)
      ##1 1'b1 |=> performance_report_control_q == ($past(hwdata[7:0]) & PRC_CTRL_MASK))
    else $error("control write not stored");

  chk_ctrl_readback: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_phase && !hwrite && haddr[11:0] == PRC_ADDR_CTRL)
      |=> hrdata == {24'h000000, performance_report_control_q})
    else $error("control readback wrong");

  chk_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("slave stalled or errored");

  chk_count_tracks: assert property (@(posedge hclk) disable iff (!hresetn)
    rpt_valid |=> rpt_cnt_q == 8'($past(rpt_cnt_q) + 8'h01))
    else $error("report count not advanced");

  cov_status_read: cover property (@(posedge hclk) disable iff (!hresetn)
    addr_phase && !hwrite && haddr[11:0] == PRC_ADDR_STATUS);
  cov_los_driven: cover property (@(posedge hclk) disable iff (!hresetn)
    $fell(signal_loss_output_pin_n));

endmodule : prc_top

// File: perf_report_control_test.sv
module perf_report_control_test import prc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // A short report interval keeps the periodic checks within a few hundred cycles.
  localparam int FC  = 4;
  localparam int FPS = 3;
  localparam int PER = FC * FPS;

  logic             hclk     = 1'b0;  // Bus clock.
  logic             hresetn  = 1'b0;  // Reset, active low.
  logic             hsel     = 1'b0;  // Slave select.
  logic [31:0]      haddr    = 32'h0; // Address.
  logic [1:0]       htrans   = 2'h0;  // Transfer type.
  logic             hwrite   = 1'b0;  // Write flag.
  logic [2:0]       hsize    = 3'h2;  // Always a word.
  logic [31:0]      hwdata   = 32'h0; // Write data.
  logic             hreadyout;        // Slave ready, fed back as hready.
  logic             hresp;            // Slave response.
  logic [31:0]      hrdata;           // Read data.
  logic             ais      = 1'b0;  // Transmitter sends AIS.
  logic             sh       = 1'b0;  // Short haul configuration.
  logic [4:0]       eq       = 5'h0;  // Configured build-out.
  logic [4:0]       eq_out;           // Applied build-out.
  logic             los_det  = 1'b0;  // Receive loss detected.
  logic             pin_n;            // Loss pin, active low.
  logic [15:0]      cnt_sum  = 16'h0; // Counter summary.
  logic             rep_valid;        // Report strobe.
  prc_report_t      rep;              // Report contents.
  int               errors    = 0;
  int               tests_run = 0;
  int               nrep      = 0;
  logic [31:0]      seed      = 32'h9B3D1411;
  logic             rd_pend   = 1'b0;
  logic [31:0]      rdq[$];
  prc_report_t      repq[$];
  time              rep_t[$];

  prc_top #(.FRAME_CYCLES(FC), .FRAMES_PER_SEC(FPS)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ais_sending(ais),
    .short_haul(sh), .equalizer_setting(eq), .equalizer_setting_out(eq_out),
    .signal_loss_detect(los_det), .signal_loss_output_pin_n(pin_n),
    .performance_monitor_counters(cnt_sum), .report_valid(rep_valid), .report(rep)
  );

  // The clock toggles every half period of 5 ns.
  always #5 hclk = ~hclk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : check

  task automatic report_and_stop();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  // Waits for a ready edge; a slave that never answers counts as a mismatch.
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) check(32'h1, 32'h0);
  endtask : wait_rdy

  task automatic ahb_wr(input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    hwrite <= 1'b1;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask : ahb_wr

  // The expected value is queued here and compared by the monitor at the data edge.
  task automatic ahb_rd(input logic [11:0] a, input logic [31:0] exp);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    hwrite <= 1'b0;
    htrans <= 2'h2;
    wait_rdy();
    htrans  <= 2'h0;
    rd_pend <= 1'b1;
    rdq.push_back(exp);
    wait_rdy();
    rd_pend <= 1'b0;
  endtask : ahb_rd

  // Lets level outputs settle two edges, then samples away from the active edge.
  task automatic settle();
    repeat (2) @(posedge hclk);
    @(negedge hclk);
  endtask : settle

  // Optionally leaves periodic mode mid-interval first, so the restart is exercised.
  task automatic periodic(input int n, input bit pre);
    time t0;
    int  idx;
    cnt_sum <= 16'(rnd());
    @(posedge hclk);
    if (pre) begin
      ahb_wr(PRC_ADDR_CTRL, 32'h6);
      repeat (PER / 2) @(posedge hclk);
      ahb_wr(PRC_ADDR_CTRL, 32'h4);
    end
    for (int k = 0; k < n; k++) repq.push_back({1'b1, cnt_sum});
    nrep += n;
    ahb_wr(PRC_ADDR_CTRL, 32'h6);
    t0 = $time;
    repeat (n * PER + 2) @(posedge hclk);
    ahb_rd(PRC_ADDR_STATUS, {16'h0, nrep[7:0], 8'h01});
    ahb_wr(PRC_ADDR_CTRL, 32'h4);
    idx = rep_t.size() - n;
    check(32'h1, 32'((rep_t[idx] - t0) >= PER * 10 && (rep_t[idx] - t0) <= (PER + 2) * 10));
    for (int k = 1; k < n; k++) check(PER * 10, 32'(rep_t[idx + k] - rep_t[idx + k - 1]));
  endtask : periodic

  // Monitor: takes the oldest note off a queue whenever a read or a report appears.
  always @(posedge hclk) begin
    if (rd_pend) begin
      check(rdq.pop_front(), hrdata);
      check(32'h0, {31'h0, hresp});
    end
    if (hresetn && rep_valid === 1'b1) begin
      rep_t.push_back($time);
      if (repq.size() == 0) check(32'h0, 32'h1);
      else check({15'h0, repq.pop_front()}, {15'h0, rep});
    end
  end

  // Watchdog sized well beyond the few hundred cycles the sequence needs.
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    logic [31:0] d;
    logic [4:0]  s;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb_rd(PRC_ADDR_CTRL, {24'h0, PRC_CTRL_RESET});
    ahb_rd(PRC_ADDR_STATUS, 32'h0);
    // Register readback with random data, mode kept at 00 so no report fires.
    for (int i = 0; i < 4; i++) begin
      d = rnd() & 32'hFFFFFFFC;
      ahb_wr(PRC_ADDR_CTRL, d);
      ahb_rd(PRC_ADDR_CTRL, d & 32'hC4);
    end
    ahb_wr(12'h008, rnd());
    ahb_rd(12'h010, 32'h0);
    ahb_rd(PRC_ADDR_CTRL, d & 32'hC4);
    // Loss pin gating over every enable and detect combination.
    for (int i = 0; i < 4; i++) begin
      ahb_wr(PRC_ADDR_CTRL, {25'h0, i[1], 6'h0});
      los_det <= i[0];
      settle();
      check({31'h0, ~(i[1] & i[0])}, {31'h0, pin_n});
      @(posedge hclk);
    end
    // Build-out lowering over all enable, AIS and short haul combinations, then setting 0.
    for (int i = 0; i < 9; i++) begin
      s = (i == 8) ? 5'h0 : 5'(rnd() % 31 + 1);
      ahb_wr(PRC_ADDR_CTRL, {24'h0, (i[2] | i[3]), 7'h40});
      ais <= i[1] | i[3];
      sh  <= i[0] | i[3];
      eq  <= s;
      settle();
      check({27'h0, s - 5'(i == 7)}, {27'h0, eq_out});
      @(posedge hclk);
    end
    ahb_rd(PRC_ADDR_STATUS, 32'h0);
    eq  <= 5'h9;
    @(posedge hclk);
    ahb_rd(PRC_ADDR_STATUS, 32'h2);
    ais <= 1'b0;
    // Single reports for both C/R values; repeats, 11 and 11 to 01 must stay silent.
    for (int c = 0; c < 2; c++) begin
      cnt_sum <= 16'(rnd());
      @(posedge hclk);
      repq.push_back({c[0], cnt_sum});
      ahb_wr(PRC_ADDR_CTRL, {29'h0, c[0], 2'h1});
      repeat (4) @(posedge hclk);
      ahb_wr(PRC_ADDR_CTRL, {29'h0, c[0], 2'h1});
      ahb_wr(PRC_ADDR_CTRL, {29'h0, c[0], 2'h3});
      repeat (4) @(posedge hclk);
      ahb_wr(PRC_ADDR_CTRL, {29'h0, c[0], 2'h1});
      repeat (4) @(posedge hclk);
      ahb_wr(PRC_ADDR_CTRL, {29'h0, c[0], 2'h0});
      repq.push_back({c[0], cnt_sum});
      ahb_wr(PRC_ADDR_CTRL, {29'h0, c[0], 2'h1});
      repeat (4) @(posedge hclk);
      ahb_wr(PRC_ADDR_CTRL, 32'h0);
      nrep += 2;
    end
    ahb_rd(PRC_ADDR_STATUS, {16'h0, nrep[7:0], 8'h00});
    periodic(3, 1'b0);
    periodic(1, 1'b1);
    repeat (2 * PER) @(posedge hclk);
    check(32'h0, repq.size());
    report_and_stop();
  end
endmodule : perf_report_control_test
